// >>> core/vdma_defs.svh
`ifndef VDMA_DEFS_SVH
`define VDMA_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CTRL_ADDR 8'h00
`define INT_ADDR 8'h04
`define STAT_ADDR 8'h08

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CTRL_ENABLE 0
`define CTRL_PLANAR 1
`define CTRL_THR_LO 2
`define CTRL_THR_HI 3
`define CTRL_RESET 4'h0
`define INT_PARITY 0
`define INT_SLOW 1
`define INT_RESYNC 2

// ----------------------------------------------------------------
// FIFO levels, threshold base and status codes
// ----------------------------------------------------------------
`define FIFO_FULL_LEVEL 6'h22
`define FIFO_ALMOST_FULL_LEVEL 6'h20
`define THR_BASE 6'h04
`define DWORD_BYTES 12'h004
`define LINE_START_CODE 4'h1
`define LINE_END_CODE 4'h2
`define EVEN_FIELD_END_CODE 4'h3
`define ODD_FIELD_END_CODE 4'h4

`endif

// >>> core/vdma_pkg.sv
package vdma_pkg;

	// Instruction kinds presented by the fetch path.
	typedef enum logic [1:0] {
		OP_WRITE = 2'h0,
		OP_SKIP = 2'h1,
		OP_SYNC = 2'h2,
		OP_BAD = 2'h3
	} op_t;

	// Sequencer states.
	typedef enum logic [3:0] {
		S_IDLE, S_FETCH, S_SYNC, S_WAIT, S_ADDR,
		S_BURST, S_DROP, S_ALIGN, S_TAIL, S_HALT
	} state_t;

endpackage

// >>> core/video_dma_fifo_sequencer.sv
// Operation
// RQ1: write waits for selected FIFO threshold
// RQ2: threshold ignored when remainder fits FIFO
// RQ3: skip instructions ignore the threshold
// RQ4: software sets equal thresholds in planar
// RQ5: planar disconnect re-requests, ignores threshold
// RQ6: instruction parity error halts, raises interrupt
// RQ7: denied bus means pop and discard
// RQ8: byte position kept through overruns
// RQ9: address phase only below almost-full
// RQ10: all three FIFO counters checked
// RQ11: overflow awaiting target ends, flags slow
// RQ12: overrun continues into next instruction, line
// RQ13: count discarded lines, realign instructions
// RQ14: luma first, full chroma discarded alongside
// RQ15: early line end aborts to marked instruction
// RQ16: long line discarded until line end
// RQ17: early field end aborts until sync
// RQ18: long field discarded until sync matches
// RQ19: every correction sets resync status bit
// RQ20: only one function sees grant
// RQ21: request ORed, grant steered, parks video
// RQ22: audio wins if requesting at grant
// RQ23: no preemption during a transaction
// RQ24: discard FIFO until sync status matches
// RQ25: each FIFO word carries four status bits
// RQ26: interrupt status bits sticky until cleared
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "vdma_defs.svh"

module video_dma_fifo_sequencer (
	input wire logic hclk, // Bus and PCI clock.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [7:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Transfer size.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready.
	output logic [31:0] hrdata, // Read data.
	output logic hreadyout, // Slave ready.
	output logic hresp, // Always OKAY.
	output logic instr_req, // Asks for the next instruction.
	input wire logic instr_valid, // Instruction word present.
	input wire logic [1:0] instr_op, // Instruction kind.
	input wire logic [11:0] instr_bytes, // Byte count.
	input wire logic instr_eol, // Last instruction of a line.
	input wire logic [3:0] instr_status, // Sync status field.
	input wire logic instr_parity_err, // Parity error on fetch.
	input wire logic [5:0] fifo_count0, // Packed or luma count.
	input wire logic [5:0] fifo_count1, // First chroma count.
	input wire logic [5:0] fifo_count2, // Second chroma count.
	input wire logic [3:0] fifo_status, // Status of the head word.
	output logic pop0, // Pops the packed or luma FIFO.
	output logic pop1, // Pops the first chroma FIFO.
	output logic pop2, // Pops the second chroma FIFO.
	output logic burst_start, // Starts an address phase.
	output logic burst_stop, // Ends the transaction.
	input wire logic target_ready, // Target took a data word.
	input wire logic target_stop, // Target disconnected us.
	input wire logic audio_req, // Audio function request.
	output logic audio_gnt, // Grant seen by audio.
	output logic pci_req_n, // External bus request.
	input wire logic pci_gnt_n, // External bus grant pin.
	input wire logic pci_frame_n, // Frame pin.
	input wire logic pci_irdy_n // Initiator ready pin.
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	vdma_pkg::state_t state;
	logic [3:0] ctrl;
	logic [2:0] int_status;
	logic [7:0] a_addr;
	logic a_wr;
	logic [1:0] gnt_sync, frame_sync, irdy_sync;
	logic gnt_s, busy_s, lock, owner, video_gnt, vid_req;
	logic [5:0] cnt [3];
	logic [11:0] bytes;
	logic [3:0] want;
	logic eol_flag, carry, flush, term, align;
	logic field_abort, at_field_end;
	logic [7:0] lines_dropped;
	logic any_full, any_afull, thr_ok, at_eol, planar;
	logic [5:0] thr;
	logic [9:0] rem_dw;
	logic [2:0] pop_ok, chroma_full;
	logic set_parity, set_slow, set_resync, last_pop;

	assign cnt[0] = fifo_count0;
	assign cnt[1] = fifo_count1;
	assign cnt[2] = fifo_count2;
	assign planar = ctrl[`CTRL_PLANAR];
	assign gnt_s = gnt_sync[1];
	assign busy_s = ~frame_sync[1] | ~irdy_sync[1];

	// A FIFO may be popped only while it holds a word that is not already in flight.
	function automatic logic can_pop(input logic [5:0] c, input logic p);
		can_pop = (c > 6'h01) || (c == 6'h01 && !p);
	endfunction

	// ----------------------------------------------------------------
	// FIFO level checks
	// ----------------------------------------------------------------
	// Every counter is watched in both modes.
	always_comb begin
		any_full = 1'b0;
		any_afull = 1'b0;
		for (int i = 0; i < 3; i++) begin
			any_full = any_full | (cnt[i] >= `FIFO_FULL_LEVEL); // RQ10
			any_afull = any_afull | (cnt[i] >= `FIFO_ALMOST_FULL_LEVEL);
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_lvl
			assign chroma_full[g] = cnt[g] >= `FIFO_FULL_LEVEL;
		end
	endgenerate

	assign pop_ok[0] = can_pop(cnt[0], pop0);
	assign pop_ok[1] = can_pop(cnt[1], pop1);
	assign pop_ok[2] = can_pop(cnt[2], pop2);

	// Threshold is four DWORDs shifted by the selected step.
	assign thr = `THR_BASE << ctrl[`CTRL_THR_HI:`CTRL_THR_LO]; // RQ1
	assign rem_dw = 10'((bytes + 12'h003) >> 2);
	assign thr_ok = (cnt[0] >= thr) // RQ1
		|| ({4'h0, cnt[0]} > rem_dw) // RQ2
		|| flush; // RQ5
	assign at_eol = fifo_status == `LINE_END_CODE;
	assign at_field_end = fifo_status == `EVEN_FIELD_END_CODE ||
		fifo_status == `ODD_FIELD_END_CODE;
	assign last_pop = bytes <= `DWORD_BYTES;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Grant, frame and ready pins pass two flops before use.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gnt_sync <= 2'h0;
			frame_sync <= 2'h3;
			irdy_sync <= 2'h3;
		end else begin
			gnt_sync <= {gnt_sync[0], ~pci_gnt_n};
			frame_sync <= {frame_sync[0], pci_frame_n};
			irdy_sync <= {irdy_sync[0], pci_irdy_n};
		end
	end

	// ----------------------------------------------------------------
	// Function arbiter
	// ----------------------------------------------------------------
	// Audio steers the grant until it is locked by an owner.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock <= 1'b0;
			owner <= 1'b0;
			video_gnt <= 1'b0;
			audio_gnt <= 1'b0;
			pci_req_n <= 1'b1;
		end else begin
			pci_req_n <= ~(vid_req | audio_req); // RQ21
			if (!lock) begin
				owner <= audio_req; // RQ22
				// A parked grant is not locked, so audio can still steer it.
				lock <= gnt_s & (audio_req | vid_req);
			end else if (!busy_s && (!gnt_s ||
				!(owner ? audio_req : vid_req))) begin
				lock <= 1'b0; // RQ23
			end
			video_gnt <= gnt_s & ~(lock ? owner : audio_req); // RQ20
			audio_gnt <= gnt_s & (lock ? owner : audio_req); // RQ20
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Instruction flow, bursts, discards and realignment.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= vdma_pkg::S_IDLE;
			instr_req <= 1'b0;
			bytes <= 12'h000;
			want <= 4'h0;
			eol_flag <= 1'b0;
			carry <= 1'b0;
			flush <= 1'b0;
			term <= 1'b0;
			align <= 1'b0;
			field_abort <= 1'b0;
			lines_dropped <= 8'h00;
			vid_req <= 1'b0;
			pop0 <= 1'b0;
			pop1 <= 1'b0;
			pop2 <= 1'b0;
			burst_start <= 1'b0;
			burst_stop <= 1'b0;
			set_parity <= 1'b0;
			set_slow <= 1'b0;
			set_resync <= 1'b0;
		end else begin
			pop0 <= 1'b0;
			pop1 <= 1'b0;
			pop2 <= 1'b0;
			burst_start <= 1'b0;
			burst_stop <= 1'b0;
			set_parity <= 1'b0;
			set_slow <= 1'b0;
			set_resync <= 1'b0;
			instr_req <= 1'b0;
			if (!ctrl[`CTRL_ENABLE]) begin
				state <= vdma_pkg::S_IDLE;
				vid_req <= 1'b0;
				carry <= 1'b0;
				align <= 1'b0;
				field_abort <= 1'b0;
				lines_dropped <= 8'h00;
			end else begin
				unique case (state)
				vdma_pkg::S_IDLE: begin
					state <= vdma_pkg::S_FETCH;
				end
				vdma_pkg::S_FETCH: begin
					instr_req <= ~instr_valid;
					if (instr_valid && instr_parity_err) begin
						set_parity <= 1'b1; // RQ6
						vid_req <= 1'b0; // RQ6
						state <= vdma_pkg::S_HALT; // RQ6
					end else if (instr_valid && lines_dropped != 8'h00) begin
						if (instr_eol) begin
							lines_dropped <= lines_dropped - 8'h01; // RQ13
						end
					end else if (instr_valid && align) begin
						align <= ~instr_eol; // RQ15
					end else if (instr_valid && field_abort) begin
						// Instructions are dropped up to the next sync.
						if (vdma_pkg::op_t'(instr_op) == vdma_pkg::OP_SYNC) begin
							field_abort <= 1'b0; // RQ17
							want <= instr_status;
							state <= vdma_pkg::S_SYNC;
						end
					end else if (instr_valid) begin
						bytes <= instr_bytes;
						want <= instr_status;
						eol_flag <= instr_eol;
						unique case (vdma_pkg::op_t'(instr_op))
						vdma_pkg::OP_SYNC: state <= vdma_pkg::S_SYNC;
						vdma_pkg::OP_SKIP: state <= vdma_pkg::S_DROP; // RQ3
						vdma_pkg::OP_WRITE: state <= carry ?
							vdma_pkg::S_DROP : vdma_pkg::S_WAIT; // RQ12
						vdma_pkg::OP_BAD: state <= vdma_pkg::S_HALT;
						endcase
					end else if (carry && any_full) begin
						state <= vdma_pkg::S_TAIL; // RQ12
					end
				end
				vdma_pkg::S_SYNC: begin
					// Status nibble of each word is matched here.
					if (cnt[0] != 6'h00 && fifo_status == want) begin // RQ25
						carry <= 1'b0;
						state <= vdma_pkg::S_FETCH;
					end else if (pop_ok[0]) begin
						pop0 <= 1'b1; // RQ24
						pop1 <= planar & pop_ok[1];
						pop2 <= planar & pop_ok[2];
						if (at_field_end) begin
							set_resync <= 1'b1; // RQ18
						end
					end
				end
				vdma_pkg::S_WAIT: begin
					vid_req <= 1'b1;
					if (at_field_end && cnt[0] != 6'h00) begin
						set_resync <= 1'b1; // RQ19
						field_abort <= 1'b1; // RQ17
						vid_req <= 1'b0;
						state <= vdma_pkg::S_FETCH;
					end else if (at_eol && !eol_flag && cnt[0] != 6'h00) begin
						set_resync <= 1'b1; // RQ19
						align <= 1'b1; // RQ15
						vid_req <= 1'b0;
						state <= vdma_pkg::S_FETCH;
					end else if (any_full) begin
						vid_req <= 1'b0;
						carry <= 1'b1;
						state <= vdma_pkg::S_DROP; // RQ7
					end else if (video_gnt && thr_ok && !any_afull) begin
						burst_start <= 1'b1; // RQ9
						term <= 1'b0;
						state <= vdma_pkg::S_ADDR;
					end
				end
				vdma_pkg::S_ADDR: begin
					if (any_full && !term) begin
						term <= 1'b1;
						set_slow <= 1'b1; // RQ11
					end
					if (target_ready && (term || any_full)) begin
						burst_stop <= 1'b1; // RQ11
						vid_req <= 1'b0;
						carry <= 1'b1;
						state <= vdma_pkg::S_DROP; // RQ11
					end else if (target_ready) begin
						state <= vdma_pkg::S_BURST;
					end
				end
				vdma_pkg::S_BURST: begin
					flush <= 1'b0;
					pop1 <= planar & chroma_full[1] & pop_ok[1]; // RQ14
					pop2 <= planar & chroma_full[2] & pop_ok[2]; // RQ14
					if (target_stop) begin
						flush <= planar; // RQ5
						state <= vdma_pkg::S_WAIT; // RQ5
					end else if (target_ready && pop_ok[0]) begin
						pop0 <= 1'b1;
						bytes <= last_pop ? 12'h000 : bytes - `DWORD_BYTES;
						if (last_pop) begin
							burst_stop <= 1'b1;
							vid_req <= 1'b0;
							if (eol_flag && !at_eol) begin
								set_resync <= 1'b1; // RQ16
								state <= vdma_pkg::S_TAIL; // RQ16
							end else begin
								state <= vdma_pkg::S_FETCH;
							end
						end
					end
				end
				vdma_pkg::S_DROP: begin
					// Discard keeps the byte position current.
					if (at_field_end && cnt[0] != 6'h00) begin
						set_resync <= 1'b1; // RQ19
						field_abort <= 1'b1; // RQ17
						state <= vdma_pkg::S_FETCH;
					end else if (at_eol && !eol_flag && cnt[0] != 6'h00) begin
						set_resync <= 1'b1; // RQ19
						align <= 1'b1; // RQ15
						state <= vdma_pkg::S_FETCH;
					end else if (pop_ok[0]) begin
						pop0 <= 1'b1; // RQ7
						pop1 <= planar & pop_ok[1];
						pop2 <= planar & pop_ok[2];
						bytes <= last_pop ? 12'h000 : bytes - `DWORD_BYTES; // RQ8
						if (last_pop) begin
							carry <= carry & any_afull; // RQ12
							state <= vdma_pkg::S_FETCH;
						end
					end
				end
				vdma_pkg::S_TAIL: begin
					vid_req <= 1'b1;
					if (pop_ok[0]) begin
						pop0 <= 1'b1; // RQ16
						pop1 <= planar & pop_ok[1];
						pop2 <= planar & pop_ok[2];
						if (at_eol && carry && !video_gnt) begin
							lines_dropped <= lines_dropped + 8'h01; // RQ13
						end else if (at_eol) begin
							carry <= 1'b0;
							vid_req <= 1'b0;
							state <= vdma_pkg::S_FETCH; // RQ13
						end
					end
				end
				vdma_pkg::S_HALT: begin
					vid_req <= 1'b0;
				end
				default: begin
					state <= vdma_pkg::S_HALT;
				end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	// Address phase is captured; the write lands in the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_addr <= 8'h00;
			a_wr <= 1'b0;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			a_wr <= 1'b0;
			if (hsel && hready && htrans[1]) begin
				a_addr <= haddr;
				a_wr <= hwrite;
				unique case (haddr)
				`CTRL_ADDR: hrdata <= {28'h0, ctrl};
				`INT_ADDR: hrdata <= {29'h0, int_status};
				`STAT_ADDR: hrdata <= {8'h00, lines_dropped,
					bytes, 4'(state)};
				default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control register written by software.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= `CTRL_RESET;
		end else if (a_wr && a_addr == `CTRL_ADDR) begin
			ctrl <= hwdata[3:0];
		end
	end

	// Sticky event bits, write one to clear, a new event wins.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_status <= 3'h0;
		end else begin
			int_status <= (int_status & ~((a_wr && a_addr == `INT_ADDR) ?
				hwdata[2:0] : 3'h0)) |
				{set_resync, set_slow, set_parity}; // RQ26
		end
	end

endmodule

// >>> tb/pci_host_model.sv
`timescale 1ns/1ps
module pci_host_model (
	input wire logic hclk, // Clock.
	input wire logic hresetn, // Reset, active low.
	input wire logic deny, // Withholds the grant.
	input wire logic slow, // Long target latency.
	input wire logic burst_start, // Address phase begins.
	input wire logic burst_stop, // Transaction ends.
	output logic pci_gnt_n, // Grant, active low.
	output logic pci_frame_n, // Frame, active low.
	output logic pci_irdy_n, // Initiator ready, active low.
	output logic target_ready, // Word accepted.
	output logic target_stop // Disconnect.
);
	int wait_cnt;

	// The arbiter parks on the device unless told to withhold.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pci_gnt_n <= 1'b1;
		else
			pci_gnt_n <= deny;
	end
	// One transaction; the target answers after a short or long wait.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pci_frame_n <= 1'b1;
			wait_cnt <= 0;
			target_ready <= 1'b0;
		end else if (burst_start) begin
			pci_frame_n <= 1'b0;
			wait_cnt <= 0;
		end else if (burst_stop || pci_frame_n) begin
			pci_frame_n <= 1'b1;
			target_ready <= 1'b0;
		end else begin
			wait_cnt <= wait_cnt + 1;
			target_ready <= wait_cnt >= (slow ? 12 : 1);
		end
	end
	assign pci_irdy_n = pci_frame_n;
	assign target_stop = 1'b0;
endmodule

// >>> tb/tb_video_dma_fifo_sequencer.sv
`timescale 1ns/1ps
`include "vdma_defs.svh"
module tb_video_dma_fifo_sequencer;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0, instr_op = 2'h0;
	logic [31:0] hwdata = 32'h00000000, hrdata, rd;
	logic hreadyout, hresp, instr_req, pop0, pop1, pop2, audio_gnt;
	logic burst_start, burst_stop, pci_req_n, pci_gnt_n, pci_frame_n;
	logic pci_irdy_n, target_ready, target_stop;
	logic instr_valid = 1'b0, instr_perr = 1'b0, audio_req = 1'b0;
	logic deny = 1'b0, slow = 1'b0;
	logic [11:0] instr_bytes = 12'h000;
	logic [3:0] fifo_status = 4'h0;
	int cnt0 = 0, cnt1 = 0, pops = 0, thr, sel;
	int fail_count = 0, comparisons = 0, cycles = 0;
	bit hit;

	always #50 hclk = ~hclk;
	// Occupancy model: each pop0 removes one word from cnt0 the next cycle.
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (pop0 === 1'b1) begin
			pops <= pops + 1;
			cnt0 <= (cnt0 > 0) ? cnt0 - 1 : 0;
		end
		if (cycles == 20000) begin
			fail_count++;
			final_report();
		end
	end

	video_dma_fifo_sequencer dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.instr_req(instr_req), .instr_valid(instr_valid),
		.instr_op(instr_op), .instr_bytes(instr_bytes), .instr_eol(1'b0),
		.instr_status(`LINE_START_CODE), .instr_parity_err(instr_perr),
		.fifo_count0(cnt0[5:0]), .fifo_count1(cnt1[5:0]),
		.fifo_count2(cnt1[5:0]), .fifo_status(fifo_status),
		.pop0(pop0), .pop1(pop1), .pop2(pop2), .burst_start(burst_start),
		.burst_stop(burst_stop), .target_ready(target_ready),
		.target_stop(target_stop), .audio_req(audio_req),
		.audio_gnt(audio_gnt), .pci_req_n(pci_req_n),
		.pci_gnt_n(pci_gnt_n), .pci_frame_n(pci_frame_n),
		.pci_irdy_n(pci_irdy_n));
	pci_host_model host (.hclk(hclk), .hresetn(hresetn), .deny(deny),
		.slow(slow), .burst_start(burst_start), .burst_stop(burst_stop),
		.pci_gnt_n(pci_gnt_n), .pci_frame_n(pci_frame_n),
		.pci_irdy_n(pci_irdy_n), .target_ready(target_ready),
		.target_stop(target_stop));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Compares one value and counts the result.
	task automatic chk(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One single word transfer; read data lands in rd.
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		@(posedge hclk);
	endtask
	// Hands over one instruction once the sequencer asks.
	task automatic fetch(input logic [1:0] op, input logic [11:0] b,
		input logic perr);
		do @(posedge hclk); while (instr_req !== 1'b1);
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_bytes <= b;
		instr_perr <= perr;
		@(posedge hclk);
		instr_valid <= 1'b0;
		instr_perr <= 1'b0;
	endtask
	// Watches a window of cycles for an address phase.
	task automatic see_start(input int lim);
		hit = 0;
		repeat (lim) begin
			@(posedge hclk);
			if (burst_start === 1'b1) hit = 1;
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h94EC));
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		chk("req idle", pci_req_n, 1'b1);
		ahb(1'b0, `CTRL_ADDR, 0);
		chk("ctrl reset", rd, 32'h00000000);
		ahb(1'b0, `INT_ADDR, 0);
		chk("int reset", rd, 32'h00000000);
		ahb(1'b1, 8'h0C, $urandom);
		ahb(1'b0, 8'h0C, 0);
		chk("unmapped", rd, 32'h00000000);
		$display("registers done");
		audio_req <= 1'b1;
		repeat (8) @(posedge hclk);
		chk("req or", pci_req_n, 1'b0);
		chk("audio wins", audio_gnt, 1'b1);
		audio_req <= 1'b0;
		repeat (10) @(posedge hclk);
		chk("parks video", audio_gnt, 1'b0);
		$display("arbiter done");
		sel = $urandom % 3;
		thr = 4 << sel;
		ahb(1'b1, `CTRL_ADDR, 32'h1 | (sel << 2));
		ahb(1'b0, `CTRL_ADDR, 0);
		chk("ctrl", rd & 32'hF, 32'h1 | (sel << 2));
		cnt0 <= 1;
		fifo_status <= `LINE_START_CODE;
		fetch(vdma_pkg::OP_SYNC, 12'h000, 1'b0);
		// The start code stays at the head until the sync state sees it.
		@(posedge hclk);
		fifo_status <= 4'h0;
		cnt0 <= thr - 1;
		fetch(vdma_pkg::OP_WRITE, 12'(thr * 4), 1'b0);
		see_start(30);
		chk("below trigger", hit, 1'b0);
		pops <= 0;
		cnt0 <= thr;
		see_start(40);
		chk("at trigger", hit, 1'b1);
		chk("words popped", pops, thr);
		$display("trigger done");
		cnt0 <= 3;
		fetch(vdma_pkg::OP_WRITE, 12'h008, 1'b0);
		pops <= 0;
		see_start(40);
		chk("tail burst", hit, 1'b1);
		chk("tail pops", pops, 2);
		$display("tail done");
		slow <= 1'b1;
		cnt0 <= 4;
		fetch(vdma_pkg::OP_WRITE, 12'h00C, 1'b0);
		repeat (40) begin
			@(posedge hclk);
			if (burst_start === 1'b1) break;
		end
		cnt1 <= `FIFO_FULL_LEVEL;
		repeat (30) @(posedge hclk);
		ahb(1'b0, `INT_ADDR, 0);
		chk("slow bit", rd & 32'h7, 32'h2);
		ahb(1'b0, `INT_ADDR, 0);
		chk("slow sticky", rd & 32'h7, 32'h2);
		ahb(1'b1, `INT_ADDR, 32'h2);
		ahb(1'b0, `INT_ADDR, 0);
		chk("slow clear", rd & 32'h7, 32'h0);
		cnt1 <= 0;
		slow <= 1'b0;
		// A line end lets the discarded line tail finish.
		cnt0 <= 1;
		fifo_status <= `LINE_END_CODE;
		repeat (4) @(posedge hclk);
		fifo_status <= 4'h0;
		chk("line end", instr_req, 1'b1);
		$display("slow target done");
		deny <= 1'b1;
		repeat (6) @(posedge hclk);
		pops <= 0;
		cnt0 <= `FIFO_FULL_LEVEL;
		fetch(vdma_pkg::OP_WRITE, 12'h028, 1'b0);
		repeat (60) @(posedge hclk);
		chk("discarded", pops, 10);
		chk("below full", cnt0 < `FIFO_FULL_LEVEL, 1'b1);
		deny <= 1'b0;
		$display("overrun done");
		fifo_status <= `EVEN_FIELD_END_CODE;
		cnt0 <= 3;
		fetch(vdma_pkg::OP_WRITE, 12'h008, 1'b0);
		see_start(20);
		chk("field abort", hit, 1'b0);
		ahb(1'b0, `INT_ADDR, 0);
		chk("resync bit", rd & 32'h7, 32'h4);
		ahb(1'b1, `INT_ADDR, 32'h4);
		fifo_status <= 4'h0;
		$display("field end done");
		fetch(vdma_pkg::OP_WRITE, 12'h010, 1'b1);
		repeat (10) @(posedge hclk);
		chk("halted", instr_req, 1'b0);
		ahb(1'b0, `INT_ADDR, 0);
		chk("parity bit", rd & 32'h1, 32'h1);
		ahb(1'b1, `INT_ADDR, 32'h1);
		ahb(1'b0, `INT_ADDR, 0);
		chk("parity clear", rd & 32'h1, 32'h0);
		ahb(1'b1, `CTRL_ADDR, 0);
		$display("parity done");
		final_report();
	end
endmodule

// >>> tb/vdma_monitor.sv
`timescale 1ns/1ps
`include "vdma_defs.svh"
module vdma_monitor (
	input wire logic hclk, // Clock.
	input wire logic hresetn, // Reset, active low.
	input wire logic instr_req, // Fetch request.
	input wire logic instr_valid, // Instruction present.
	input wire logic instr_parity_err, // Fetch parity error.
	input wire logic [5:0] fifo_count0, // Luma count.
	input wire logic [5:0] fifo_count1, // Chroma count.
	input wire logic [5:0] fifo_count2, // Chroma count.
	input wire logic pop0, // Luma pop.
	input wire logic burst_start, // Address phase.
	input wire logic audio_req, // Audio request.
	input wire logic audio_gnt, // Audio grant.
	input wire logic pci_req_n, // External request.
	input wire logic pci_gnt_n, // External grant.
	input wire logic pci_frame_n, // Frame pin.
	input wire logic pci_irdy_n // Ready pin.
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ----------------------------------------------------------------
	// Arbiter
	// ----------------------------------------------------------------
	// An audio request reaches the bus pin one cycle later.
	chk_req_or: assert property (audio_req |=> !pci_req_n)
		else $error("audio request not passed to bus pin");
	// Audio sees a grant only after the pin grant and its own request.
	chk_gnt_pipe: assert property ($rose(audio_gnt) |->
		(!$past(pci_gnt_n, 2) || !$past(pci_gnt_n, 3)) &&
		($past(audio_req) || $past(audio_req, 2)))
		else $error("audio grant without cause");
	// With no audio request on an idle bus the grant parks on video.
	chk_gnt_park: assert property ((!audio_req && pci_frame_n &&
		pci_irdy_n)[*6] |-> !audio_gnt)
		else $error("grant not parked on video");
	// Video never starts while audio holds the grant.
	chk_burst_excl: assert property (burst_start |-> !$past(audio_gnt))
		else $error("burst while audio granted");

	// ----------------------------------------------------------------
	// FIFO levels and halting
	// ----------------------------------------------------------------
	// Address phase only below the almost full level.
	chk_burst_luma: assert property (burst_start |->
		$past(fifo_count0) < `FIFO_ALMOST_FULL_LEVEL)
		else $error("burst started at almost full");
	// Chroma counters are watched as well.
	chk_burst_chroma: assert property (burst_start |->
		$past(fifo_count1) < `FIFO_ALMOST_FULL_LEVEL &&
		$past(fifo_count2) < `FIFO_ALMOST_FULL_LEVEL)
		else $error("burst started at chroma almost full");
	// A parity error on fetch stops fetching and bursting.
	chk_parity_halt: assert property (instr_req && instr_valid &&
		instr_parity_err |-> ##2 (!instr_req && !burst_start)[*6])
		else $error("activity after parity error");
	// Discarding pops only words that exist.
	chk_pop_nonempty: assert property (pop0 |-> $past(fifo_count0) != 0)
		else $error("pop from empty fifo");
endmodule

bind video_dma_fifo_sequencer vdma_monitor mon (.hclk, .hresetn,
	.instr_req, .instr_valid, .instr_parity_err, .fifo_count0,
	.fifo_count1, .fifo_count2, .pop0, .burst_start, .audio_req,
	.audio_gnt, .pci_req_n, .pci_gnt_n, .pci_frame_n, .pci_irdy_n);
